// *** irq_bank_cfg.svh ***
// Register offsets, field positions and reset values of the primary interrupt bank.
// Assumes inclusion by the bank module only.
`ifndef IRQ_BANK_CFG_SVH
`define IRQ_BANK_CFG_SVH
// ==========================================
// Byte offsets on the register bus
`define OFS_PIN_EDGE_SELECT 4'h0
`define OFS_IRQ_CONTROL_PRIMARY 4'h4
`define OFS_IRQ_CONTROL_SECONDARY 4'h8
`define OFS_IRQ_CONTROL_TERTIARY 4'hc
`define OFS_IRQ_PENDING 8'h10
// ==========================================
// Edge select fields
`define POS_PIN_A_EDGE 0
`define POS_PIN_B_EDGE 2
// ==========================================
// Primary control fields
`define POS_GLOBAL_EN 0
`define POS_PIN_A_EN 1
`define POS_PIN_B_EN 2
`define POS_CMP_A_EN 3
`define POS_PIN_A_FLAG 4
`define POS_PIN_B_FLAG 5
`define POS_CMP_A_FLAG 6
// ==========================================
// Secondary control fields
`define POS_CMP_B_EN 0
`define POS_GROUP0_EN 1
`define POS_GROUP1_EN 2
`define POS_CONV_EN 3
`define POS_CMP_B_FLAG 4
`define POS_GROUP0_FLAG 5
`define POS_GROUP1_FLAG 6
`define POS_CONV_FLAG 7
// ==========================================
// Tertiary control fields
`define POS_GROUP2_EN 0
`define POS_TICK_A_EN 1
`define POS_TICK_B_EN 2
`define POS_GROUP3_EN 3
`define POS_GROUP2_FLAG 4
`define POS_TICK_A_FLAG 5
`define POS_TICK_B_FLAG 6
`define POS_GROUP3_FLAG 7
// ==========================================
// Reset values and read masks
`define RST_REG 8'h00
`define MASK_EDGE 8'h0f
`define MASK_PRIMARY 8'h7f
`define MASK_SECONDARY_NO_CONV 8'h77
`define MASK_FULL 8'hff
`endif

// *** irq_bank_pkg.sv ***
// Types shared by the primary interrupt bank.
// Assumes no other package.
package irq_bank_pkg;
    // ==========================================
    // Trigger codes of an external pin
    typedef enum logic [1:0] {
        EDGE_OFF = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_mode_t;
    typedef enum logic [1:0] {
        RESP_OKAY = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_t;
endpackage : irq_bank_pkg

// *** primary_interrupt_control.sv ***
// Primary interrupt request and enable bank with an AXI4-Lite register slave.
// Assumes pins and peripheral request pulses are synchronous to clock.
//
// Notes on behaviour
// R1 - Bits 3:2 of the edge register pick pin B's trigger: off, rising, falling or both.
// R2 - Bits 1:0 of the edge register pick pin A's trigger with the same four codes.
// R3 - Bits 7:4 of the edge register read as zero.
// R4 - Bit 7 of the secondary register is a read/write converter request flag.
// R5 - Without a converter, bits 7 and 3 of the secondary register read as zero.
// R6 - Bits 5 and 6 of the secondary register are group 0 and group 1 request flags.
// R7 - Bits 1 and 2 of the secondary register enable group 0 and group 1.
// R8 - Bit 4 of the secondary register is comparator B's flag and bit 0 its enable.
// R9 - Bits 7:4 of the tertiary register are flags for group 3, tick B, tick A, group 2.
// R10 - Bits 3:0 of the tertiary register are enables for group 3, tick B, tick A, group 2.
// R11 - The CPU request rises only when a flag, its enable and the global enable are all set.
// R12 - A pin flag is set on the selected edge and held until software writes zero to it.
`include "irq_bank_cfg.svh"
module primary_interrupt_control
    import irq_bank_pkg::*;
#(
    parameter bit HAS_CONVERTER = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // External pins and peripheral request pulses
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic cmp_a_req,
    input wire logic cmp_b_req,
    input wire logic conv_req,
    input wire logic [3:0] group_req,
    input wire logic tick_a_req,
    input wire logic tick_b_req,
    // Request to the CPU
    output logic cpu_irq,
    // AXI4-Lite write address and data
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import irq_bank_pkg::*;

    // ==========================================
    // State
    logic [7:0] edge_q, edge_d;
    logic [7:0] prim_q, prim_d;
    logic [7:0] sec_q, sec_d;
    logic [7:0] ter_q, ter_d;
    logic pin_a_q, pin_a_d, pin_b_q, pin_b_d;
    logic irq_q, irq_d;
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [4:0] awaddr_q, awaddr_d;
    logic [7:0] wdata_q, wdata_d;
    logic wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [7:0] rdata_q, rdata_d;
    logic pin_a_hit, pin_b_hit, do_write, rd_take;
    logic [7:0] sec_mask, rd_val;
    logic rd_ok;
    logic [10:0] pend;

    function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
        logic rise;
        logic fall;
        rise = !prev && cur;
        fall = prev && !cur;
        unique case (edge_mode_t'(mode))
            EDGE_OFF: edge_hit = 1'b0;
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            EDGE_BOTH: edge_hit = rise || fall;
        endcase
    endfunction : edge_hit

    // ==========================================
    // Edge detection and flag bank
    always_comb begin
        // Converter absent: its flag and enable cannot be stored, so they read as zero
        sec_mask = HAS_CONVERTER ? `MASK_FULL : `MASK_SECONDARY_NO_CONV; // R5
        pin_a_d = ext_irq_pin_a;
        pin_b_d = ext_irq_pin_b;
        pin_a_hit = edge_hit(edge_q[`POS_PIN_A_EDGE +: 2], pin_a_q, ext_irq_pin_a); // R2
        pin_b_hit = edge_hit(edge_q[`POS_PIN_B_EDGE +: 2], pin_b_q, ext_irq_pin_b); // R1
        do_write = aw_full_q && w_full_q && !bvalid_q;
        edge_d = edge_q;
        prim_d = prim_q;
        sec_d = sec_q;
        ter_d = ter_q;
        if (do_write && wstrb_q) begin
            unique case (awaddr_q[4:0])
                5'(`OFS_PIN_EDGE_SELECT): edge_d = wdata_q & `MASK_EDGE; // R3
                5'(`OFS_IRQ_CONTROL_PRIMARY): prim_d = wdata_q & `MASK_PRIMARY;
                5'(`OFS_IRQ_CONTROL_SECONDARY): sec_d = wdata_q & sec_mask; // R4 R6 R7 R8
                5'(`OFS_IRQ_CONTROL_TERTIARY): ter_d = wdata_q; // R9 R10
                default: ;
            endcase
        end
        // Hardware sets win over a software clear in the same cycle
        if (pin_a_hit) prim_d[`POS_PIN_A_FLAG] = 1'b1; // R12
        if (pin_b_hit) prim_d[`POS_PIN_B_FLAG] = 1'b1; // R12
        if (cmp_a_req) prim_d[`POS_CMP_A_FLAG] = 1'b1;
        if (cmp_b_req) sec_d[`POS_CMP_B_FLAG] = 1'b1; // R8
        if (group_req[0]) sec_d[`POS_GROUP0_FLAG] = 1'b1; // R6
        if (group_req[1]) sec_d[`POS_GROUP1_FLAG] = 1'b1; // R6
        if (conv_req && HAS_CONVERTER) sec_d[`POS_CONV_FLAG] = 1'b1; // R4
        if (group_req[2]) ter_d[`POS_GROUP2_FLAG] = 1'b1; // R9
        if (tick_a_req) ter_d[`POS_TICK_A_FLAG] = 1'b1; // R9
        if (tick_b_req) ter_d[`POS_TICK_B_FLAG] = 1'b1; // R9
        if (group_req[3]) ter_d[`POS_GROUP3_FLAG] = 1'b1; // R9
        // One term per source keeps each flag paired with its own enable if a field moves
        pend[0] = prim_q[`POS_PIN_A_FLAG] && prim_q[`POS_PIN_A_EN];
        pend[1] = prim_q[`POS_PIN_B_FLAG] && prim_q[`POS_PIN_B_EN];
        pend[2] = prim_q[`POS_CMP_A_FLAG] && prim_q[`POS_CMP_A_EN];
        pend[3] = sec_q[`POS_CMP_B_FLAG] && sec_q[`POS_CMP_B_EN];
        pend[4] = sec_q[`POS_GROUP0_FLAG] && sec_q[`POS_GROUP0_EN];
        pend[5] = sec_q[`POS_GROUP1_FLAG] && sec_q[`POS_GROUP1_EN];
        pend[6] = sec_q[`POS_CONV_FLAG] && sec_q[`POS_CONV_EN] && HAS_CONVERTER; // R5
        pend[7] = ter_q[`POS_GROUP2_FLAG] && ter_q[`POS_GROUP2_EN]; // R10
        pend[8] = ter_q[`POS_TICK_A_FLAG] && ter_q[`POS_TICK_A_EN]; // R10
        pend[9] = ter_q[`POS_TICK_B_FLAG] && ter_q[`POS_TICK_B_EN]; // R10
        pend[10] = ter_q[`POS_GROUP3_FLAG] && ter_q[`POS_GROUP3_EN]; // R10
        irq_d = prim_q[`POS_GLOBAL_EN] && |pend; // R11
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            edge_q <= `RST_REG;
            prim_q <= `RST_REG;
            sec_q <= `RST_REG;
            ter_q <= `RST_REG;
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            edge_q <= edge_d;
            prim_q <= prim_d;
            sec_q <= sec_d;
            ter_q <= ter_d;
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================
    // Register bus slave
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        // A channel item is taken only at a valid and ready edge
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata[7:0];
            wstrb_d = s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (awaddr_q[1:0] == 2'h0 && awaddr_q <= 5'(`OFS_IRQ_CONTROL_TERTIARY))
                      ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        rd_take = s_axi_arvalid && s_axi_arready;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            5'(`OFS_PIN_EDGE_SELECT): rd_val = edge_q; // R3
            5'(`OFS_IRQ_CONTROL_PRIMARY): rd_val = prim_q;
            5'(`OFS_IRQ_CONTROL_SECONDARY): rd_val = sec_q & sec_mask; // R5
            5'(`OFS_IRQ_CONTROL_TERTIARY): rd_val = ter_q;
            default: begin
                rd_val = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rd_take) begin
            rvalid_d = 1'b1;
            rdata_d = rd_val;
            rresp_d = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 5'h00;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q <= 8'h00;
            rresp_q <= 2'h0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Ready is registered state: a channel is ready while its holding slot is empty
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_full_d && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_full_d && !(s_axi_wvalid && s_axi_wready);
            s_axi_arready <= !rvalid_d && !(s_axi_arvalid && s_axi_arready);
        end
    end

    assign cpu_irq = irq_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = {24'h000000, rdata_q};
    assign s_axi_rresp = rresp_q;
endmodule : primary_interrupt_control

// *** irq_source_model.sv ***
// Far-side model: two external pins and nine request sources.
// Assumes the bench changes commands just after a rising edge.
module irq_source_model (
    // Clock
    input wire logic clock,
    // Commands from the bench
    input wire logic [1:0] pin_lvl,
    input wire logic [8:0] fire,
    // Pins and requests to the bank
    output logic ext_irq_pin_a,
    output logic ext_irq_pin_b,
    output logic [8:0] req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Registered so pins never move on the sampling edge
    always_ff @(posedge clock) begin
        {ext_irq_pin_b, ext_irq_pin_a} <= pin_lvl;
        req <= fire;
    end
endmodule : irq_source_model

// *** primary_interrupt_control_asserts.sv ***
// Port checker for the primary interrupt bank.
// Assumes it is bound to the top module.
module irq_bank_checker
    import irq_bank_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Observed ports
    input wire logic cpu_irq,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ==========
    // Address of the read in flight
    logic [4:0] raddr_q, raddr_d;
    logic mapped;
    always_comb begin
        raddr_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : raddr_q;
    end
    always_ff @(posedge clock) begin
        raddr_q <= rst ? 5'h00 : raddr_d;
    end
    assign mapped = (raddr_q[1:0] == 2'h0) && (raddr_q <= 5'h0c);
    // ==========
    // Reset itself must quiet the outputs, so no disable here
    property p_rst_quiet;
        disable iff (1'b0) rst |=> !cpu_irq && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
    property p_read_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read answer late");
    property p_write_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_write_lat: assert property (p_write_lat) else $error("write answer late");
    property p_upper_zero;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_edge_hi;
        s_axi_rvalid && raddr_q == 5'h00 |-> s_axi_rdata[7:4] == 4'h0;
    endproperty
    a_edge_hi: assert property (p_edge_hi) else $error("edge register top nibble set");
    property p_unmapped;
        s_axi_rvalid && !mapped |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_mapped_ok;
        s_axi_rvalid && mapped |-> s_axi_rresp == RESP_OKAY;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped read refused");
    property p_gen_off;
        s_axi_rvalid && raddr_q == 5'h04 && !s_axi_rdata[0] |=> !cpu_irq;
    endproperty
    a_gen_off: assert property (p_gen_off) else $error("request with global enable off");
endmodule : irq_bank_checker
bind primary_interrupt_control irq_bank_checker irq_bank_checker_inst (.clock, .rst, .cpu_irq,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

// *** test_primary_interrupt_control.sv ***
// Testbench for the primary interrupt bank over AXI4-Lite.
// Assumes the source model and checker are compiled first.
module test_primary_interrupt_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [1:0] pin_lvl = 2'h0;
    logic [8:0] fire = 9'h000;
    logic [8:0] req;
    logic pin_a, pin_b, cpu_irq, awready, wready, bvalid, arready, rvalid;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0] bresp, rresp;
    logic [1:0] wr_resp = 2'h0;
    logic [3:0] wstrb = 4'hf;
    logic cpu_irq_nc;
    logic [31:0] rdata_nc;
    int mismatches = 0, tests_run = 0, cycles = 0;
    // Order: cmp a, cmp b, conv, groups 0..3, tick a, tick b
    logic [4:0] src_addr [9] = '{5'h04, 5'h08, 5'h08, 5'h08, 5'h08, 5'h0c, 5'h0c, 5'h0c, 5'h0c};
    int fb [9] = '{6, 4, 7, 5, 6, 4, 7, 5, 6};
    int eb [9] = '{3, 0, 3, 1, 2, 0, 3, 1, 2};
    always #2 clock = ~clock;
    irq_source_model irq_source_model_inst (.clock, .pin_lvl, .fire, .ext_irq_pin_a(pin_a),
        .ext_irq_pin_b(pin_b), .req);
    primary_interrupt_control primary_interrupt_control_inst (.clock, .rst, .ext_irq_pin_a(pin_a),
        .ext_irq_pin_b(pin_b), .cmp_a_req(req[0]), .cmp_b_req(req[1]), .conv_req(req[2]),
        .group_req(req[6:3]), .tick_a_req(req[7]), .tick_b_req(req[8]), .cpu_irq,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // Same bus and sources, no converter: its handshakes track the main instance cycle for cycle
    primary_interrupt_control #(.HAS_CONVERTER(1'b0)) primary_interrupt_control_noconv_inst (.clock, .rst,
        .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .cmp_a_req(req[0]), .cmp_b_req(req[1]), .conv_req(req[2]),
        .group_req(req[6:3]), .tick_a_req(req[7]), .tick_b_req(req[8]), .cpu_irq(cpu_irq_nc),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
        .s_axi_rdata(rdata_nc), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready));
    // ==========
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        wr_resp = bresp;
    endtask : wr
    task rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("rdata", rdata, e);
    endtask : rd
    task wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // Whole run needs a few hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    // ==========
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        wr(5'h10, 8'hff);
        chk("bresp", 32'(wr_resp), 32'h2);
        for (int a = 0; a < 5; a++) rd(5'(a * 4), 32'h0);
        rd(5'h05, 32'h0);
        $display("test reset done");
        wr(5'h00, 8'hff);
        wr(5'h08, 8'hff);
        wr(5'h0c, 8'hff);
        wr(5'h04, 8'hff);
        rd(5'h00, 32'h0f);
        rd(5'h04, 32'h7f);
        rd(5'h08, 32'hff);
        chk("rdata_nc", rdata_nc, 32'h77);
        rd(5'h0c, 32'hff);
        chk("cpu_irq", 32'(cpu_irq), 32'h1);
        for (int a = 0; a < 4; a++) wr(5'(a * 4), 8'h00);
        wstrb <= 4'h0;
        wr(5'h0c, 8'h55);
        wstrb <= 4'hf;
        chk("bresp", 32'(wr_resp), 32'h0);
        rd(5'h0c, 32'h0);
        $display("test masks done");
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(5'h00, 8'(m << (2 * p)));
                wr(5'h04, 8'h00);
                pin_lvl[p] <= 1'b1;
                repeat (4) @(posedge clock);
                rd(5'h04, m[0] ? 32'(1 << (4 + p)) : 32'h0);
                wr(5'h04, 8'h00);
                pin_lvl[p] <= 1'b0;
                repeat (4) @(posedge clock);
                rd(5'h04, m[1] ? 32'(1 << (4 + p)) : 32'h0);
            end
        end
        $display("test pins done");
        for (int i = 0; i < 9; i++) begin
            wr(5'h04, 8'h01);
            wr(5'h08, 8'h00);
            wr(5'h0c, 8'h00);
            fire[i] <= 1'b1;
            @(posedge clock);
            fire[i] <= 1'b0;
            repeat (3) @(posedge clock);
            rd(src_addr[i], 32'((1 << fb[i]) | (src_addr[i] == 5'h04)));
            if (i == 2) chk("rdata_nc", rdata_nc, 32'h0);
            chk("cpu_irq", 32'(cpu_irq), 32'h0);
            wr(src_addr[i], 8'((1 << fb[i]) | (1 << eb[i]) | (src_addr[i] == 5'h04)));
            repeat (3) @(posedge clock);
            chk("cpu_irq", 32'(cpu_irq), 32'h1);
            if (i == 2) chk("cpu_irq_nc", 32'(cpu_irq_nc), 32'h0);
        end
        wr(5'h04, 8'h00);
        repeat (3) @(posedge clock);
        chk("cpu_irq", 32'(cpu_irq), 32'h0);
        $display("test sources done");
        wrap_up();
    end
endmodule : test_primary_interrupt_control
